// ### rtl/rx_pp_pkg.sv
// constants, types and state layout of the receive pre-processing and held-frame buffer
// Overview of operation
// - good frame with legal length and CRC interrupts when receive_config bit 8 set
// - frame with bad CRC interrupts when receive_config bit C set
// - short frames (bit D) and frames over 1518 bytes (bit E) interrupt
// - frame-status interrupts only for frames that passed the address filter
// - buffer_config bit 7 interrupts when frames were moved by DMA
// - buffer_config bit A interrupts when a frame is dropped for lack of space
// - buffer_config bit D interrupts when the missed-frame counter overflows
// - receive_config bits 7, 9, A select streaming, all-DMA and auto-switch
// - receive_config bit B keeps the FCS in the buffer, else it is dropped
// - bus_control bit B limits each DMA bus hold to about 28 us
// - every frame passes the address filter first; failing frames are discarded
// - destination-arrived flag sets on address pass unless a committed frame waits (then dropped); host may read six bytes
// - after 128 bytes first-block flag sets and destination flag clears
// - first-block flag clears on buffer_event read or at end of frame
// - event bits other than first-block and destination clear only by host read of their register or of the ESQ
// - acceptance control decides buffering; outcome reported in receive events
// - end-of-frame interrupts come after buffering, at most 1518 bytes buffered
// - space committed on receive-event read of complete frame or early read
// - committed space is never written by a later frame
// - committed frame freed by full read, skip bit 6, or implied skip
// - early interrupts suppressed while a committed frame waits
// - no interrupt unless master enable bus_control bit F is set
package rx_pp_pkg;

  localparam logic [7:0] OFS_RX_CFG   = 8'h0C;
  localparam logic [7:0] OFS_RX_EVENT = 8'h10;
  localparam logic [7:0] OFS_ACCEPT   = 8'h14;
  localparam logic [7:0] OFS_BUF_CFG  = 8'h2C;
  localparam logic [7:0] OFS_BUF_EVT  = 8'h30;
  localparam logic [7:0] OFS_MISSED   = 8'h40;
  localparam logic [7:0] OFS_BUS_CTL  = 8'h5C;
  localparam logic [7:0] OFS_LENGTH   = 8'h64;
  localparam logic [7:0] OFS_DATA     = 8'h68;
  localparam logic [7:0] OFS_ESQ      = 8'h80;

  localparam int B_SKIP     = 6;
  localparam int B_STREAM   = 7;
  localparam int B_GOOD     = 8;
  localparam int B_DMA_ALL  = 9;
  localparam int B_AUTO_DMA = 10;
  localparam int B_KEEP_FCS = 11;
  localparam int B_BAD_FCS  = 12;
  localparam int B_SHORT    = 13;
  localparam int B_LONG     = 14;
  localparam int B_DMA_DONE = 7;
  localparam int B_MISSED   = 10;
  localparam int B_FIRST    = 11;
  localparam int B_WRAP     = 13;
  localparam int B_DEST     = 15;
  localparam int B_HOLD_LIM = 11;
  localparam int B_BUF_SIZE = 13;
  localparam int B_MASTER   = 15;

  localparam logic [15:0] RX_IRQ_MASK   = 16'h7100;
  localparam logic [15:0] BUF_LATE_MASK = 16'h2480;
  localparam logic [15:0] EARLY_MASK    = 16'h8800;
  localparam logic [15:0] REG_RESET     = 16'h0000;
  localparam logic [5:0]  ESQ_NUM_RX    = 6'h04;
  localparam logic [5:0]  ESQ_NUM_BUF   = 6'h0C;

  localparam logic [10:0] SHORT_LEN   = 11'd64;
  localparam logic [10:0] MAX_LEN     = 11'd1518;
  localparam logic [10:0] FIRST_BLOCK = 11'd128;
  localparam logic [10:0] FCS_LEN     = 11'd4;
  localparam int          BUF_WORDS   = 380;

  localparam int          CLK_NS       = 100;
  localparam int          DMA_HOLD_NS  = 28000;
  localparam logic [8:0]  DMA_HOLD_CYC = 9'(DMA_HOLD_NS / CLK_NS);

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_BODY = 2'b10,
    ST_DROP = 2'b11
  } rx_state_e;

  typedef struct packed {
    logic       awvalid;
    logic [7:0] awaddr;
    logic       wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic       bready;
    logic       arvalid;
    logic [7:0] araddr;
    logic       rready;
  } axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_s;

  typedef struct packed {
    logic       start;
    logic       valid;
    logic [7:0] data;
    logic       da_done;
    logic       da_pass;
    logic       eof;
    logic       crc_ok;
  } rx_in_s;

  typedef struct packed {
    axi_rsp_s                       rsp;
    logic                           aw_have;
    logic [7:0]                     aw_addr;
    logic                           w_have;
    logic [31:0]                    w_data;
    logic [3:0]                     w_strb;
    logic [15:0]                    rx_cfg;
    logic [15:0]                    rx_event;
    logic [15:0]                    accept;
    logic [15:0]                    buf_cfg;
    logic [15:0]                    buf_event;
    logic [15:0]                    bus_ctl;
    logic [9:0]                     missed;
    rx_state_e                      state;
    logic [10:0]                    cnt;
    logic [10:0]                    held_len;
    logic                           held_valid;
    logic                           done;
    logic                           committed;
    logic                           other_seen;
    logic [8:0]                     rd_ptr;
    logic [BUF_WORDS-1:0][31:0]     mem;
    logic [8:0]                     dma_cnt;
    logic                           dma_yield;
    logic                           irq;
  } st_s;

endpackage

// ### rtl/rx_frame_preprocess_buffer.sv
// receive pre-processing, early events and held-frame buffer with an AXI4-Lite register slave
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module rx_frame_preprocess_buffer import rx_pp_pkg::*; (
  input  wire logic     aclk,
  input  wire logic     aresetn,
  input  wire axi_req_s axi_req,
  output axi_rsp_s      axi_rsp,
  input  wire rx_in_s   rx_in,
  input  wire logic     dma_done,
  input  wire logic     dma_active,
  output logic          irq,
  output logic          dma_yield,
  output logic          streaming_en,
  output logic          dma_for_all_frames,
  output logic          auto_switch_dma_en,
  output logic          dma_buffer_size_sel,
  output logic          keep_fcs
);

  st_s         s;
  st_s         n;
  logic [15:0] rx_set;
  logic [15:0] rx_clr;
  logic [15:0] buf_set;
  logic [15:0] buf_clr;
  logic        rd_rx;
  logic        rd_buf;
  logic        free;
  logic        accept_hit;
  logic [10:0] len_kept;
  logic [31:0] rdata;
  logic [1:0]  rresp;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = d[7:0];
    end
    if (strb[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  function automatic logic [10:0] sat_inc(input logic [10:0] v);
    return (v == 11'h7FF) ? v : v + 11'd1;
  endfunction

  assign axi_rsp             = s.rsp;
  assign irq                 = s.irq;
  assign dma_yield           = s.dma_yield;
  assign streaming_en        = s.rx_cfg[B_STREAM];
  assign dma_for_all_frames  = s.rx_cfg[B_DMA_ALL];
  assign auto_switch_dma_en  = s.rx_cfg[B_AUTO_DMA];
  assign dma_buffer_size_sel = s.bus_ctl[B_BUF_SIZE];
  assign keep_fcs            = s.rx_cfg[B_KEEP_FCS];

  always_comb begin
    n          = s;
    rx_set     = '0;
    rx_clr     = '0;
    buf_set    = '0;
    buf_clr    = '0;
    rd_rx      = 1'b0;
    rd_buf     = 1'b0;
    free       = 1'b0;
    accept_hit = 1'b0;
    len_kept   = '0;
    rdata      = '0;
    rresp      = RESP_OKAY;

    // write channel: address and data are parked independently, then applied together
    if (axi_req.awvalid && s.rsp.awready) begin
      n.aw_have = 1'b1;
      n.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      n.w_have = 1'b1;
      n.w_data = axi_req.wdata;
      n.w_strb = axi_req.wstrb;
    end
    if (s.rsp.bvalid && axi_req.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (s.aw_have && s.w_have) begin
      n.aw_have        = 1'b0;
      n.w_have         = 1'b0;
      n.rsp.bvalid     = 1'b1;
      n.rsp.bresp      = RESP_OKAY;
      unique case (s.aw_addr)
        OFS_RX_CFG: begin
          n.rx_cfg         = merge(s.rx_cfg, s.w_data, s.w_strb);
          n.rx_cfg[B_SKIP] = 1'b0;
          // skip frees the visible frame whatever has been read of it
          if (s.w_strb[0] && s.w_data[B_SKIP]) begin
            free = 1'b1;
          end
        end
        OFS_ACCEPT:  n.accept  = merge(s.accept, s.w_data, s.w_strb);
        OFS_BUF_CFG: n.buf_cfg = merge(s.buf_cfg, s.w_data, s.w_strb);
        OFS_BUS_CTL: n.bus_ctl = merge(s.bus_ctl, s.w_data, s.w_strb);
        OFS_RX_EVENT, OFS_BUF_EVT, OFS_MISSED, OFS_LENGTH, OFS_DATA, OFS_ESQ: begin
        end
        default: n.rsp.bresp = RESP_SLVERR;
      endcase
    end

    // read channel: side effects of a read act on the cycle the address is taken
    if (s.rsp.rvalid && axi_req.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && s.rsp.arready) begin
      unique case (axi_req.araddr)
        OFS_RX_CFG:   rdata = {16'h0000, s.rx_cfg};
        OFS_ACCEPT:   rdata = {16'h0000, s.accept};
        OFS_BUF_CFG:  rdata = {16'h0000, s.buf_cfg};
        OFS_BUS_CTL:  rdata = {16'h0000, s.bus_ctl};
        OFS_MISSED:   rdata = {22'h000000, s.missed};
        OFS_LENGTH:   rdata = {21'h000000, s.held_len};
        OFS_RX_EVENT: begin
          rdata = {16'h0000, s.rx_event};
          rd_rx = 1'b1;
        end
        OFS_BUF_EVT: begin
          rdata  = {16'h0000, s.buf_event};
          rd_buf = 1'b1;
        end
        OFS_ESQ: begin
          if (s.rx_event != 16'h0000) begin
            rdata = {16'h0000, s.rx_event[15:6], ESQ_NUM_RX};
            rd_rx = 1'b1;
          end else if (s.buf_event != 16'h0000) begin
            rdata  = {16'h0000, s.buf_event[15:6], ESQ_NUM_BUF};
            rd_buf = 1'b1;
          end
        end
        OFS_DATA: begin
          // data is visible for a complete held frame or an early-committed one
          if (s.held_valid || s.committed) begin
            rdata    = s.mem[s.rd_ptr];
            n.rd_ptr = s.rd_ptr + 9'd1;
            if (s.done && ({s.rd_ptr + 9'd1, 2'b00} >= s.held_len)) begin
              free = 1'b1;
            end
          end
        end
        default: rresp = RESP_SLVERR;
      endcase
      n.rsp.rvalid = 1'b1;
      n.rsp.rdata  = rdata;
      n.rsp.rresp  = rresp;
    end

    if (rd_rx) begin
      rx_clr = 16'hFFFF;
      if (s.committed && s.other_seen && (s.rd_ptr != 9'd0)) begin
        free = 1'b1;
      end else if (s.held_valid && s.done) begin
        n.committed = 1'b1;
      end
    end
    if (rd_buf) begin
      buf_clr = 16'hFFFF;
      if ((s.state == ST_BODY) && ((s.buf_event & EARLY_MASK) != 16'h0000)) begin
        n.committed = 1'b1;
      end
    end

    if (dma_done) begin
      buf_set[B_DMA_DONE] = 1'b1;
    end

    // frame path
    if (rx_in.start) begin
      n.state = ST_ADDR;
      n.cnt   = '0;
      if (!n.committed) begin
        n.held_valid = 1'b0;
        n.done       = 1'b0;
        n.rd_ptr     = '0;
      end
    end else begin
      unique case (s.state)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          // the address bytes only land if no held frame owns the space
          if (rx_in.valid) begin
            if (!s.committed) begin
              n.mem[s.cnt[10:2]][{s.cnt[1:0], 3'b000} +: 8] = rx_in.data;
            end
            n.cnt = sat_inc(s.cnt);
          end
          if (rx_in.eof) begin
            n.state = ST_IDLE;
          end else if (rx_in.da_done) begin
            if (!rx_in.da_pass) begin
              n.state = ST_DROP;
            end else if (s.committed) begin
              n.state              = ST_DROP;
              n.other_seen         = 1'b1;
              buf_set[B_MISSED]    = 1'b1;
              n.missed             = s.missed + 10'd1;
              buf_set[B_WRAP]      = (s.missed == 10'h3FF);
            end else begin
              n.state         = ST_BODY;
              buf_set[B_DEST] = 1'b1;
            end
          end
        end
        ST_BODY: begin
          if (rx_in.valid) begin
            if (s.cnt < MAX_LEN) begin
              n.mem[s.cnt[10:2]][{s.cnt[1:0], 3'b000} +: 8] = rx_in.data;
            end
            n.cnt = sat_inc(s.cnt);
            if (s.cnt == FIRST_BLOCK - 11'd1) begin
              buf_set[B_FIRST] = 1'b1;
              buf_clr[B_DEST]  = 1'b1;
            end
          end
          if (rx_in.eof) begin
            n.state          = ST_IDLE;
            buf_clr[B_FIRST] = 1'b1;
            buf_clr[B_DEST]  = 1'b1;
            rx_set[B_SHORT]   = (s.cnt < SHORT_LEN);
            rx_set[B_LONG]    = (s.cnt > MAX_LEN);
            rx_set[B_BAD_FCS] = !rx_in.crc_ok;
            rx_set[B_GOOD]    = rx_in.crc_ok && !rx_set[B_SHORT] && !rx_set[B_LONG];
            accept_hit = ((rx_set & s.accept & RX_IRQ_MASK) != 16'h0000);
            len_kept   = s.rx_cfg[B_KEEP_FCS] ? s.cnt :
                         ((s.cnt > FCS_LEN) ? s.cnt - FCS_LEN : 11'd0);
            if (len_kept > MAX_LEN) begin
              len_kept = MAX_LEN;
            end
            if (accept_hit || s.committed) begin
              n.held_valid = 1'b1;
              n.done       = 1'b1;
              n.held_len   = len_kept;
            end else begin
              n.held_valid = 1'b0;
            end
            if (!accept_hit) begin
              rx_set = '0;
            end
          end
        end
        ST_DROP: begin
          if (rx_in.eof) begin
            n.state = ST_IDLE;
          end
        end
      endcase
    end

    if (free) begin
      n.committed  = 1'b0;
      n.held_valid = 1'b0;
      n.done       = 1'b0;
      n.other_seen = 1'b0;
      n.rd_ptr     = '0;
    end

    // a hardware set in the same cycle as a read-clear survives
    n.rx_event  = (s.rx_event & ~rx_clr) | rx_set;
    n.buf_event = (s.buf_event & ~buf_clr) | buf_set;

    n.irq = n.bus_ctl[B_MASTER] &&
            (((n.rx_event & n.rx_cfg & RX_IRQ_MASK) != 16'h0000) ||
             ((n.buf_event & n.buf_cfg & BUF_LATE_MASK) != 16'h0000) ||
             (!n.committed &&
              ((n.buf_event & n.buf_cfg & EARLY_MASK) != 16'h0000)));

    // bus hold limit: the host DMA engine is told to yield after the window
    n.dma_yield = 1'b0;
    if (dma_active && s.bus_ctl[B_HOLD_LIM]) begin
      if (s.dma_cnt == DMA_HOLD_CYC - 9'd1) begin
        n.dma_yield = 1'b1;
        n.dma_cnt   = '0;
      end else begin
        n.dma_cnt = s.dma_cnt + 9'd1;
      end
    end else begin
      n.dma_cnt = '0;
    end

    n.rsp.awready = !n.aw_have && !n.rsp.bvalid;
    n.rsp.wready  = !n.w_have && !n.rsp.bvalid;
    n.rsp.arready = !n.rsp.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  irq_master_gate_a: assert property (!s.bus_ctl[B_MASTER] |-> !irq)
    else $error("interrupt raised with master enable clear");
  early_suppress_a: assert property (
    (s.committed && s.rx_event == 16'h0000 &&
     (s.buf_event & s.buf_cfg & BUF_LATE_MASK) == 16'h0000) |-> !irq)
    else $error("early interrupt while a committed frame waits");
  dest_set_a: assert property (
    (s.state == ST_ADDR && !rx_in.start && !rx_in.eof && rx_in.da_done && rx_in.da_pass &&
     !s.committed) |=> s.buf_event[B_DEST])
    else $error("destination flag not set after address pass");
  first_block_a: assert property (
    (s.state == ST_BODY && !rx_in.start && rx_in.valid && s.cnt == FIRST_BLOCK - 11'd1)
    |=> (s.buf_event[B_FIRST] && !s.buf_event[B_DEST]))
    else $error("first-block flag or destination clear missing");
  first_eof_a: assert property (
    (s.state == ST_BODY && !rx_in.start && rx_in.eof) |=> !s.buf_event[B_FIRST])
    else $error("first-block flag survived end of frame");
  rx_event_hold_a: assert property (
    (!rd_rx && s.rx_event[B_GOOD]) |=> s.rx_event[B_GOOD])
    else $error("receive event cleared without a read");
  addr_fail_a: assert property (
    (s.state == ST_ADDR && !rx_in.start && !rx_in.eof && rx_in.da_done && !rx_in.da_pass)
    |=> (s.state == ST_DROP && !s.buf_event[B_DEST]) [*1])
    else $error("frame failing the address filter not discarded");
  commit_guard_a: assert property (
    (s.committed && s.state == ST_ADDR) |=> $stable(s.mem))
    else $error("committed space written by a later frame");
  skip_free_a: assert property (
    (s.aw_have && s.w_have && s.aw_addr == OFS_RX_CFG && s.w_strb[0] && s.w_data[B_SKIP])
    |=> !s.committed && !s.held_valid)
    else $error("skip did not free the held frame");
  miss_count_a: assert property (
    (s.state == ST_ADDR && !rx_in.start && !rx_in.eof && rx_in.da_done && rx_in.da_pass &&
     s.committed) |=> (s.buf_event[B_MISSED] && s.missed == $past(s.missed) + 10'd1))
    else $error("missed frame not counted");
  dma_yield_a: assert property (
    (dma_active && s.bus_ctl[B_HOLD_LIM] && s.dma_cnt == 9'd0 && !dma_yield)
    ##1 (dma_active && s.bus_ctl[B_HOLD_LIM]) [*8] |-> !dma_yield)
    else $error("bus hold limit fired too early");

  cover_good_frame_c: cover property (s.rx_event[B_GOOD] ##[1:20] rd_rx);
  cover_early_commit_c: cover property (s.buf_event[B_FIRST] && rd_buf && s.state == ST_BODY);
  cover_missed_c: cover property (s.committed && buf_set[B_MISSED]);
  cover_full_read_c: cover property (s.committed && free && !rd_rx);

endmodule

// ### tb/rx_frame_src.sv
// line-side model that streams frames into the receive pre-processing block
`timescale 1ns/1ps
module rx_frame_src import rx_pp_pkg::*; (
  input  wire logic aclk,
  output rx_in_s    rx_in
);
  rx_in_s v;
  initial rx_in = '0;
  // idle cycles show the inverted end-of-frame data, FF, so a stale value is never mistaken for data
  task automatic idle();
    v = '0;
    v.data = ~rx_in.data;
    rx_in <= v;
  endtask
  task automatic send(input int len, input logic pass, input logic crc);
    @(posedge aclk);
    v = '0;
    v.start = 1'b1;
    rx_in <= v;
    for (int i = 0; i < len; i++) begin
      if (i == 6) begin
        @(posedge aclk);
        v = '0;
        v.da_done = 1'b1;
        v.da_pass = pass;
        rx_in <= v;
      end
      @(posedge aclk);
      v = '0;
      v.valid = 1'b1;
      v.data = i[7:0];
      rx_in <= v;
    end
    @(posedge aclk);
    v = '0;
    v.eof = 1'b1;
    v.crc_ok = crc;
    rx_in <= v;
    @(posedge aclk);
    idle();
  endtask
endmodule

// ### tb/rx_frame_preprocess_buffer_tb_top.sv
// self-checking bench: register bus, frame events, commit and free of held frames
`timescale 1ns/1ps
module rx_frame_preprocess_buffer_tb_top import rx_pp_pkg::*;;
  logic     aclk;
  logic     aresetn;
  axi_req_s req;
  axi_rsp_s rsp;
  rx_in_s   rx_in;
  logic     irq;
  logic     dma_done;
  logic     dma_active;
  logic     dma_yield;
  logic [4:0] cfg_pins;
  int       n_errors;
  int       total_checks;

  rx_frame_src i_rx_frame_src (.aclk(aclk), .rx_in(rx_in));
  rx_frame_preprocess_buffer i_rx_frame_preprocess_buffer (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .rx_in(rx_in),
    .dma_done(dma_done), .dma_active(dma_active), .irq(irq), .dma_yield(dma_yield),
    .streaming_en(cfg_pins[0]), .dma_for_all_frames(cfg_pins[1]),
    .auto_switch_dma_en(cfg_pins[2]), .keep_fcs(cfg_pins[3]),
    .dma_buffer_size_sel(cfg_pins[4]));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    req.bready <= 1'b0;
  endtask

  // reads one register and compares both data and response code
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] rs = RESP_OKAY);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    chk($sformatf("rdata %h", a), rsp.rdata, exp);
    chk($sformatf("rresp %h", a), 32'(rsp.rresp), 32'(rs));
    req.rready <= 1'b0;
  endtask

  task automatic chk_irq(input logic e);
    repeat (2) @(posedge aclk);
    chk("irq", 32'(irq), 32'(e));
  endtask

  task automatic s_reset();
    logic [7:0] regs[6] = '{OFS_RX_CFG, OFS_BUF_CFG, OFS_BUS_CTL, OFS_BUF_EVT, OFS_RX_EVENT,
                            OFS_ACCEPT};
    foreach (regs[i]) rd(regs[i], 32'(REG_RESET));
    rd(8'h04, 32'h0, RESP_SLVERR);
  endtask

  task automatic s_cfg();
    wr(OFS_RX_CFG, 32'h0E80);
    wr(OFS_BUS_CTL, 32'h2000);
    repeat (2) @(posedge aclk);
    chk("cfg pins", 32'(cfg_pins), 32'h1F);
    wr(OFS_BUS_CTL, 32'h0);
    wr(OFS_RX_CFG, 32'h0);
  endtask

  task automatic s_good();
    wr(OFS_ACCEPT, 32'h0100);
    wr(OFS_RX_CFG, 32'h0100);
    i_rx_frame_src.send(64, 1'b1, 1'b1);
    chk_irq(1'b0);
    wr(OFS_BUS_CTL, 32'h8000);
    chk_irq(1'b1);
    rd(OFS_RX_EVENT, 32'h0100);
    chk_irq(1'b0);
    rd(OFS_LENGTH, 32'd60);
    rd(OFS_DATA, 32'h03020100);
    wr(OFS_RX_CFG, 32'h0140);
    i_rx_frame_src.send(64, 1'b0, 1'b1);
    rd(OFS_RX_EVENT, 32'h0);
  endtask

  task automatic s_early();
    wr(OFS_BUF_CFG, 32'h8C00);
    fork
      i_rx_frame_src.send(200, 1'b1, 1'b1);
      begin
        repeat (140) @(posedge aclk);
        chk("irq", 32'(irq), 32'h1);
        rd(OFS_BUF_EVT, 32'h0800);
      end
    join
    rd(OFS_RX_EVENT, 32'h0100);
    i_rx_frame_src.send(64, 1'b1, 1'b1);
    chk_irq(1'b1);
    rd(OFS_BUF_EVT, 32'h0400);
    rd(OFS_MISSED, 32'h1);
    wr(OFS_RX_CFG, 32'h0140);
    i_rx_frame_src.send(64, 1'b1, 1'b1);
    rd(OFS_RX_EVENT, 32'h0100);
    rd(OFS_LENGTH, 32'd60);
    // reading every word in order releases the frame, so one more read finds nothing
    for (int k = 0; k < 15; k++) begin
      rd(OFS_DATA, {8'(4 * k + 3), 8'(4 * k + 2), 8'(4 * k + 1), 8'(4 * k)});
    end
    rd(OFS_DATA, 32'h0);
  endtask

  task automatic s_dma();
    int cyc;
    wr(OFS_BUF_CFG, 32'h0080);
    @(posedge aclk);
    dma_done <= 1'b1;
    @(posedge aclk);
    dma_done <= 1'b0;
    chk_irq(1'b1);
    rd(OFS_ESQ, 32'h008C);
    rd(OFS_ESQ, 32'h0);
    wr(OFS_BUS_CTL, 32'h8800);
    @(posedge aclk);
    dma_active <= 1'b1;
    cyc = 0;
    do begin
      @(posedge aclk);
      cyc++;
    end while (!dma_yield && cyc < 400);
    chk("yield delay", cyc, 32'(DMA_HOLD_CYC) + 32'd1);
    @(posedge aclk);
    chk("yield pulse", 32'(dma_yield), 32'h0);
    dma_active <= 1'b0;
  endtask

  task automatic s_wrap();
    i_rx_frame_src.send(64, 1'b1, 1'b1);
    rd(OFS_RX_EVENT, 32'h0100);
    // the counter stands at one, so this many drops carry it through 3FF to zero
    repeat (1023) i_rx_frame_src.send(7, 1'b1, 1'b1);
    rd(OFS_MISSED, 32'h0);
    wr(OFS_BUF_CFG, 32'h2000);
    chk_irq(1'b1);
    rd(OFS_BUF_EVT, 32'h2400);
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    n_errors++;
    close_out();
  end

  initial begin
    n_errors = 0;
    total_checks = 0;
    req = '0;
    dma_done = 1'b0;
    dma_active = 1'b0;
    aresetn = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    s_reset();
    s_cfg();
    s_good();
    s_early();
    s_dma();
    s_wrap();
    close_out();
  end
endmodule
